// ==== rtl/dvc_defs.svh ====
/*
 Offsets, field positions, reset values and timing counts of the playback
 volume and compressor control block. Assumes inclusion by bare name.
*/
`ifndef DVC_DEFS_SVH
`define DVC_DEFS_SVH

// ----------------------------------------
// Register indices and address width
// ----------------------------------------
`define DVC_IDX_LEFT_VOL      8'h41
`define DVC_IDX_RIGHT_VOL     8'h42
`define DVC_IDX_COMP_ONE      8'h44
`define DVC_IDX_COMP_TWO      8'h45
`define DVC_IDX_SOFT_STEP     8'h50
`define DVC_IDX_STATUS        8'h51
`define DVC_ADDR_W            12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DVC_LEFT_EN_BIT       6
`define DVC_RIGHT_EN_BIT      5
`define DVC_THR_HI            4
`define DVC_THR_LO            2
`define DVC_HYS_HI            1
`define DVC_HYS_LO            0
`define DVC_HOLD_HI           6
`define DVC_HOLD_LO           3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DVC_VOL_RST           8'h00
`define DVC_COMP_ONE_RST      8'h6f
`define DVC_COMP_TWO_RST      8'h38
`define DVC_SOFT_STEP_RST     2'h0

// ----------------------------------------
// Gain and timing constants
// ----------------------------------------
`define DVC_VOL_MAX           8'sh30
`define DVC_VOL_MIN           8'sh81
`define DVC_HOLD_BASE         32
`define DVC_HOLD_LONG         32768

`endif

// ==== rtl/dvc_pkg.sv ====
/*
 Types shared by the volume and compressor control block.
 Assumes nothing of its surroundings.
*/
package dvc_pkg;

	typedef enum logic [1:0] {
		DVC_STEP_EVERY  = 2'b00,
		DVC_STEP_SECOND = 2'b01,
		DVC_STEP_OFF    = 2'b10,
		DVC_STEP_RSVD   = 2'b11
	} dvc_step_t;

	typedef struct packed {
		logic        left_en;
		logic        right_en;
		logic [2:0]  threshold;
		logic [1:0]  hysteresis;
		logic [3:0]  hold;
	} dvc_comp_cfg_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] left;
		logic [15:0] right;
	} dvc_sample_t;

endpackage : dvc_pkg

// ==== rtl/dvc_gain_chan.sv ====
/*
 One playback channel: soft-stepped volume and a simple compressor with
 threshold, hysteresis and hold. Assumes one sample strobe per word clock.
*/
`include "dvc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dvc_gain_chan #(
	parameter int HOLD_LONG = `DVC_HOLD_LONG
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              word_clk,
	input  wire logic signed [7:0] vol_target,
	input  wire dvc_pkg::dvc_step_t step_mode,
	input  wire logic              comp_active,
	input  wire logic [2:0]        threshold,
	input  wire logic [1:0]        hysteresis,
	input  wire logic [3:0]        hold,
	input  wire logic signed [15:0] sample_in,
	output logic signed [15:0]     sample_out,
	output logic signed [7:0]      vol_now,
	output logic                   comp_engaged
);
	import dvc_pkg::*;

	// Refused at elaboration so a bad hold base never reaches silicon
	if (HOLD_LONG < 1) begin : g_bad_hold
		$error("HOLD_LONG must be positive");
	end

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Level in half-dB below full scale of a 16-bit sample, coarse log2
	function automatic logic [7:0] half_db_down(input logic signed [15:0] s);
		logic [15:0] m;
		logic [7:0]  r;
		m = s[15] ? 16'(-s) : s;
		r = 8'h60;
		for (int i = 0; i < 15; i++) begin
			if (m[i])
				r = 8'(12 * (14 - i));
		end
		return r;
	endfunction

	function automatic logic [19:0] hold_count(input logic [3:0] code);
		logic [19:0] n;
		n = 20'h0;
		if (code >= 4'h1 && code <= 4'h5)
			n = 20'(`DVC_HOLD_BASE << (code - 4'h1));
		else if (code == 4'he)
			n = 20'(4 * HOLD_LONG);
		else if (code == 4'hf)
			n = 20'(5 * HOLD_LONG);
		return n;
	endfunction

	// ----------------------------------------
	// Volume soft stepping
	// ----------------------------------------
	logic step_phase_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vol_now        <= 8'sh00;
			step_phase_reg <= 1'b0;
		end else if (word_clk) begin
			step_phase_reg <= ~step_phase_reg;
			if (step_mode == DVC_STEP_OFF || step_mode == DVC_STEP_RSVD)
				vol_now <= vol_target;
			else if (step_mode == DVC_STEP_EVERY || step_phase_reg) begin
				if (vol_now < vol_target)
					vol_now <= vol_now + 8'sh01;
				else if (vol_now > vol_target)
					vol_now <= vol_now - 8'sh01;
			end
		end
	end

	// ----------------------------------------
	// Compressor with hysteresis and hold
	// ----------------------------------------
	logic [19:0] hold_reg;
	logic [7:0]  level;
	logic [7:0]  thr_half;
	logic [7:0]  rel_half;

	assign level    = half_db_down(sample_in);
	assign thr_half = 8'(6 * (threshold + 3'h1));
	assign rel_half = 8'(thr_half + 8'(2 * hysteresis));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_engaged <= 1'b0;
			hold_reg     <= 20'h0;
		end else if (word_clk) begin
			if (!comp_active) begin
				comp_engaged <= 1'b0;
				hold_reg     <= 20'h0;
			end else if (level < thr_half) begin
				comp_engaged <= 1'b1;
				hold_reg     <= hold_count(hold);
			end else if (comp_engaged && level > rel_half) begin
				if (hold_reg == 20'h0)
					comp_engaged <= 1'b0;
				else
					hold_reg <= hold_reg - 20'h1;
			end
		end
	end

	// ----------------------------------------
	// Gain application, one sample per word clock
	// ----------------------------------------
	logic signed [8:0] gain_half;
	logic [5:0]        sh;
	logic signed [31:0] scaled;

	// Gain is applied as 6 dB shifts; the fine half-dB steps live in vol_now only
	assign gain_half = 9'(vol_now) - (comp_engaged ? 9'sh6 : 9'sh0);
	assign sh        = gain_half[8] ? 6'(-gain_half / 12) : 6'(gain_half / 12);

	always_comb begin
		scaled = 32'(sample_in);
		if (gain_half[8])
			scaled = scaled >>> sh;
		else
			scaled = scaled <<< sh;
		if (scaled > 32'sh7fff)
			scaled = 32'sh7fff;
		else if (scaled < -32'sh8000)
			scaled = -32'sh8000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sample_out <= 16'sh0;
		else if (word_clk)
			sample_out <= scaled[15:0];
	end

endmodule : dvc_gain_chan

`default_nettype wire

// ==== rtl/dvc_regs.sv ====
/*
 Playback volume and compressor control: APB register bank plus two
 channel gain stages. Assumes APB master and a one-cycle word clock strobe.
*/
`include "dvc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dvc_regs #(
	parameter int HOLD_LONG = `DVC_HOLD_LONG
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	input  wire logic                 comp_supported,
	input  wire dvc_pkg::dvc_sample_t sample_in,
	output dvc_pkg::dvc_sample_t      sample_out
);
	import dvc_pkg::*;

	// Five long-hold units must still fit the 20-bit hold counter
	if (HOLD_LONG < 1 || HOLD_LONG > 131072) begin : g_bad_hold
		$error("HOLD_LONG out of range");
	end

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic is_reg(input logic [11:0] a, input logic [7:0] idx);
		return a == 12'({idx, 2'b00});
	endfunction

	logic access;
	logic wr;
	logic hit;

	assign access  = psel && penable;
	assign wr      = access && pwrite;
	assign pready  = 1'b1;
	assign hit     = is_reg(paddr, `DVC_IDX_LEFT_VOL) || is_reg(paddr, `DVC_IDX_RIGHT_VOL)
	              || is_reg(paddr, `DVC_IDX_COMP_ONE) || is_reg(paddr, `DVC_IDX_COMP_TWO)
	              || is_reg(paddr, `DVC_IDX_SOFT_STEP) || is_reg(paddr, `DVC_IDX_STATUS);
	assign pslverr = access && !hit;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] left_vol_reg;
	logic [7:0] right_vol_reg;
	logic [7:0] comp_one_reg;
	logic [3:0] hold_reg;
	logic [1:0] step_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_vol_reg  <= `DVC_VOL_RST;
			right_vol_reg <= `DVC_VOL_RST;
		end else if (wr) begin
			if (is_reg(paddr, `DVC_IDX_LEFT_VOL))
				left_vol_reg <= pwdata[7:0];
			if (is_reg(paddr, `DVC_IDX_RIGHT_VOL))
				right_vol_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			comp_one_reg <= `DVC_COMP_ONE_RST;
		else if (wr && is_reg(paddr, `DVC_IDX_COMP_ONE))
			comp_one_reg <= {1'b0, pwdata[6:0]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_reg <= 4'(`DVC_COMP_TWO_RST >> `DVC_HOLD_LO);
		else if (wr && is_reg(paddr, `DVC_IDX_COMP_TWO))
			hold_reg <= pwdata[`DVC_HOLD_HI:`DVC_HOLD_LO];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			step_reg <= `DVC_SOFT_STEP_RST;
		else if (wr && is_reg(paddr, `DVC_IDX_SOFT_STEP))
			step_reg <= pwdata[1:0];
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	logic signed [15:0] left_q;
	logic signed [15:0] right_q;
	logic signed [7:0]  left_now;
	logic signed [7:0]  right_now;
	logic               left_eng;
	logic               right_eng;
	logic               valid_reg;

	dvc_gain_chan #(.HOLD_LONG(HOLD_LONG)) u_left (
		.pclk         (pclk),
		.presetn      (presetn),
		.word_clk     (sample_in.valid),
		.vol_target   (left_vol_reg),
		.step_mode    (dvc_step_t'(step_reg)),
		.comp_active  (comp_one_reg[`DVC_LEFT_EN_BIT] && comp_supported),
		.threshold    (comp_one_reg[`DVC_THR_HI:`DVC_THR_LO]),
		.hysteresis   (comp_one_reg[`DVC_HYS_HI:`DVC_HYS_LO]),
		.hold         (hold_reg),
		.sample_in    (sample_in.left),
		.sample_out   (left_q),
		.vol_now      (left_now),
		.comp_engaged (left_eng)
	);

	dvc_gain_chan #(.HOLD_LONG(HOLD_LONG)) u_right (
		.pclk         (pclk),
		.presetn      (presetn),
		.word_clk     (sample_in.valid),
		.vol_target   (right_vol_reg),
		.step_mode    (dvc_step_t'(step_reg)),
		.comp_active  (comp_one_reg[`DVC_RIGHT_EN_BIT] && comp_supported),
		.threshold    (comp_one_reg[`DVC_THR_HI:`DVC_THR_LO]),
		.hysteresis   (comp_one_reg[`DVC_HYS_HI:`DVC_HYS_LO]),
		.hold         (hold_reg),
		.sample_in    (sample_in.right),
		.sample_out   (right_q),
		.vol_now      (right_now),
		.comp_engaged (right_eng)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			valid_reg <= 1'b0;
		else
			valid_reg <= sample_in.valid;
	end

	assign sample_out = '{valid: valid_reg, left: left_q, right: right_q};

	// ----------------------------------------
	// Read mux; registered so data come from flip-flops
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0;
			if (is_reg(paddr, `DVC_IDX_LEFT_VOL))
				prdata <= {24'h0, left_vol_reg};
			if (is_reg(paddr, `DVC_IDX_RIGHT_VOL))
				prdata <= {24'h0, right_vol_reg};
			if (is_reg(paddr, `DVC_IDX_COMP_ONE))
				prdata <= {24'h0, comp_one_reg};
			if (is_reg(paddr, `DVC_IDX_COMP_TWO))
				prdata <= {25'h0, hold_reg, 3'h0};
			if (is_reg(paddr, `DVC_IDX_SOFT_STEP))
				prdata <= {30'h0, step_reg};
			if (is_reg(paddr, `DVC_IDX_STATUS))
				prdata <= {14'h0, left_eng, right_eng, right_now, left_now};
		end
	end

endmodule : dvc_regs

`default_nettype wire

// ==== bench/dvc_regs_sva.sv ====
/*
 Port checker for the playback volume and compressor register bank.
 Assumes it is bound to every dvc_regs instance and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module dvc_regs_sva #(
	parameter int HOLD_LONG = 32768
) (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic                 pready,
	input wire logic [31:0]          prdata,
	input wire logic                 pslverr,
	input wire logic                 comp_supported,
	input wire dvc_pkg::dvc_sample_t sample_in,
	input wire dvc_pkg::dvc_sample_t sample_out
);
	import dvc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic       rd_acc;
	logic [1:0] lo_cnt;
	assign rd_acc = psel && penable && !pwrite;

	// Strobes seen since compression was last supported; engaged flags may lag one strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lo_cnt <= 2'h0;
		else if (comp_supported)
			lo_cnt <= 2'h0;
		else if (sample_in.valid && lo_cnt != 2'h3)
			lo_cnt <= lo_cnt + 2'h1;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_OUT_VALID: assert property (sample_in.valid |=> sample_out.valid)
		else $error("output strobe missing");
	AST_OUT_HOLD: assert property (!sample_in.valid |=> !sample_out.valid && $stable(sample_out.left)
		&& $stable(sample_out.right)) else $error("output moved between strobes");
	AST_VOL_WIDTH: assert property (rd_acc && paddr inside {12'h104, 12'h108} |-> prdata[31:8] == 24'h0)
		else $error("volume read too wide");
	AST_COMP_TOP_ZERO: assert property (rd_acc && paddr inside {12'h110, 12'h114} |-> !prdata[7])
		else $error("compressor bit 7 not zero");
	AST_COMP_TWO_LOW: assert property (rd_acc && paddr == 12'h114 |-> prdata[2:0] == 3'h0)
		else $error("compressor two low bits not zero");
	AST_MAPPED_OK: assert property (psel && penable && paddr inside {12'h104, 12'h108} |-> pready && !pslverr)
		else $error("volume access refused");
	AST_NO_COMP: assert property (rd_acc && paddr == 12'h144 && lo_cnt == 2'h3 |-> prdata[17:16] == 2'h0)
		else $error("compressor engaged while unsupported");
	AST_VOL_RANGE: assert property (rd_acc && paddr == 12'h144 |-> $signed(prdata[7:0]) >= -127
		&& $signed(prdata[7:0]) <= 48 && $signed(prdata[15:8]) >= -127) else $error("live volume out of range");

	cover property (sample_in.valid && comp_supported);
	cover property (psel && penable && pwrite && paddr == 12'h104);
	cover property (rd_acc && paddr == 12'h144);

endmodule // dvc_regs_sva

bind dvc_regs dvc_regs_sva #(.HOLD_LONG(HOLD_LONG)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .comp_supported(comp_supported), .sample_in(sample_in), .sample_out(sample_out));

`default_nettype wire

// ==== bench/test_dac_volume_and_compressor_ctrl.sv ====
/*
 Self-checking bench for the volume and compressor register bank.
 Assumes zero-wait APB and registered sample output.
*/
`timescale 1ns/1ps
`default_nettype none

module test_dac_volume_and_compressor_ctrl;
	import dvc_pkg::*;

	// ----------------------------------------
	// Signals and design
	// ----------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, comp_supported, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	dvc_sample_t sample_in, sample_out;
	int          n_mismatch, samples_checked, cyc;

	// Short hold base keeps long hold codes cheap to run
	dvc_regs #(.HOLD_LONG(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.comp_supported(comp_supported), .sample_in(sample_in), .sample_out(sample_out));

	always #12.5 pclk = ~pclk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout may end a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
		chk(32'(e), 32'h0);
	endtask

	// Data is inverted outside the strobe so stale values cannot pass
	task automatic smp(input logic [15:0] l, input logic [15:0] r);
		sample_in <= '{1'b1, l, r};
		@(posedge pclk);
		sample_in <= '{1'b0, ~l, ~r};
		@(posedge pclk);
	endtask

	task automatic end_sim;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, comp_supported} = '0;
		sample_in = '0;
		n_mismatch = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h104, 32'h0);
		rd(12'h108, 32'h0);
		rd(12'h110, 32'h6f);
		rd(12'h114, 32'h38);
		for (int i = 0; i < 128; i++) begin
			wr(12'h110, 32'(i));
			rd(12'h110, 32'(i));
		end
		for (int i = 0; i < 16; i++) begin
			wr(12'h114, 32'(i) << 3);
			rd(12'h114, 32'(i) << 3);
		end
		wr(12'h110, 32'h6f);
		wr(12'h114, 32'h38);
		wr(12'h104, 32'h30);
		wr(12'h108, 32'h81);
		rd(12'h104, 32'h30);
		rd(12'h108, 32'h81);
		// Unmapped word reads zero and is refused
		xfer(1'b0, 12'h10c, 32'h0);
		chk(q, 32'h0);
		chk(32'(e), 32'h1);
		// Immediate gain: -12 dB left, unity right, compressor unsupported
		wr(12'h140, 32'h2);
		wr(12'h104, 32'he8);
		wr(12'h108, 32'h0);
		smp(16'h4000, 16'hc000);
		smp(16'h4000, 16'hc000);
		chk({sample_out.left, sample_out.right}, {16'h1000, 16'hc000});
		rd(12'h144, 32'he8);
		wr(12'h140, 32'h0);
		wr(12'h104, 32'hec);
		smp(16'h0100, 16'h0100);
		rd(12'h144, 32'he9);
		repeat (4) smp(16'h0100, 16'h0100);
		rd(12'h144, 32'hec);
		wr(12'h140, 32'h1);
		wr(12'h104, 32'he8);
		smp(16'h0100, 16'h0100);
		smp(16'h0100, 16'h0100);
		rd(12'h144, 32'heb);
		comp_supported <= 1'b1;
		repeat (3) smp(16'h7fff, 16'h7fff);
		xfer(1'b0, 12'h144, 32'h0);
		chk(q & 32'h30000, 32'h30000);
		// Right compressor off: only the left one stays engaged
		wr(12'h110, 32'h4f);
		smp(16'h7fff, 16'h7fff);
		xfer(1'b0, 12'h144, 32'h0);
		chk(q & 32'h30000, 32'h20000);
		comp_supported <= 1'b0;
		repeat (3) smp(16'h7fff, 16'h7fff);
		xfer(1'b0, 12'h144, 32'h0);
		chk(q & 32'h30000, 32'h0);
		// A -6 dBFS tone stays under a -3 dBFS threshold but crosses -12 dBFS
		comp_supported <= 1'b1;
		wr(12'h110, 32'h63);
		repeat (2) smp(16'h2000, 16'h2000);
		xfer(1'b0, 12'h144, 32'h0);
		chk(q & 32'h30000, 32'h0);
		wr(12'h110, 32'h6f);
		smp(16'h2000, 16'h2000);
		xfer(1'b0, 12'h144, 32'h0);
		chk(q & 32'h30000, 32'h30000);
		// Hold of 32 word clocks keeps compression through 32 quiet samples
		wr(12'h114, 32'h08);
		smp(16'h7fff, 16'h7fff);
		repeat (32) smp(16'h0100, 16'h0100);
		xfer(1'b0, 12'h144, 32'h0);
		chk(q & 32'h30000, 32'h30000);
		smp(16'h0100, 16'h0100);
		xfer(1'b0, 12'h144, 32'h0);
		chk(q & 32'h30000, 32'h0);
		end_sim();
	end

endmodule // test_dac_volume_and_compressor_ctrl

`default_nettype wire
